// *** rtl/ssrc_buf_if.sv ***
// handshake carrier between the send engine and its two-entry buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ssrc_buf_if;
    import ssrc_pkg::*;
    logic          fill_valid;   // producer offers a byte
    logic          fill_ready;   // buffer has room
    ssrc_byte_type fill_data;    // byte offered
    logic          drain_valid;  // buffer holds a byte
    logic          drain_ready;  // consumer takes it
    ssrc_byte_type drain_data;   // oldest byte
    modport store (input fill_valid, fill_data, drain_ready, output fill_ready, drain_valid, drain_data);
    modport user  (output fill_valid, fill_data, drain_ready, input fill_ready, drain_valid, drain_data);
endinterface : ssrc_buf_if
`default_nettype wire

// *** rtl/ssrc_params.svh ***
// constants of the synchronous rate clocking block: offsets, fields, resets, timing
// assumes an 8-bit register port with a 4-bit address and a 40 MHz core clock
`ifndef SSRC_PARAMS_SVH
`define SSRC_PARAMS_SVH
// register offsets
`define SSRC_OFS_DIVCTL   4'h0
`define SSRC_OFS_EXTRA    4'h1
`define SSRC_OFS_XFEROFS  4'h2
`define SSRC_OFS_QUADTST  4'h3
`define SSRC_OFS_TEST3    4'h4
`define SSRC_OFS_STATUS   4'h5
`define SSRC_OFS_RXPER    4'h6
`define SSRC_OFS_TXPER    4'h7
`define SSRC_OFS_PENDING  4'h8
// field positions
`define SSRC_SCF_MSB      6
`define SSRC_SCF_LSB      4
`define SSRC_XH_DT_BIT    3
`define SSRC_XH_ST_BIT    2
`define SSRC_XS_DT_BIT    1
`define SSRC_XS_ST_BIT    0
`define SSRC_DT_MODE_BIT  7
`define SSRC_OFS_MSB      5
`define SSRC_ROLE_BIT     7
`define SSRC_QUAD_EN_BIT  3
`define SSRC_ACTNEG_BIT   7
// reset values and limits
`define SSRC_RST_REG      8'h00
`define SSRC_OFS_MAX_DT   6'h3E
// timing
`define SSRC_CLK_PERIOD_PS     25000
`define SSRC_REF_MHZ           40
`define SSRC_QUAD_FACTOR       4
`define SSRC_RX_MIN_PERIOD_PS  12500
`define SSRC_REF_PER_CLK       (`SSRC_CLK_PERIOD_PS * `SSRC_REF_MHZ / 1000000)
`define SSRC_HALF_STEP_BASE    (8'(2 * `SSRC_REF_PER_CLK))
`define SSRC_HALF_STEP_QUAD    (8'(2 * `SSRC_QUAD_FACTOR * `SSRC_REF_PER_CLK))
`endif

// *** rtl/ssrc_pkg.sv ***
// types shared by the synchronous rate clocking block
// assumes nothing beyond a SystemVerilog compiler
package ssrc_pkg;
    typedef logic [7:0] ssrc_byte_type;   // one bus byte or register
    typedef logic [3:0] ssrc_addr_type;   // register index
    typedef enum {SND_IDLE, SND_HOLD} ssrc_send_state_type;
endpackage : ssrc_pkg

// *** rtl/ssrc_rate_clocking.sv ***
// synchronous transfer rate clocking for a parallel bus port: divider, extra clocks, offset credit
// assumes pins from the far party are asynchronous and pass two flops; one core clock
`include "ssrc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssrc_rate_clocking (
    input  wire logic            CLK_IN,
    input  wire logic            RST_IN,
    input  wire ssrc_pkg::ssrc_addr_type REG_ADDR_IN,
    input  wire ssrc_pkg::ssrc_byte_type REG_WDATA_IN,
    input  wire logic            REG_WR_IN,
    input  wire logic            REG_RD_IN,
    output logic [7:0]           REG_RDATA_OUT,
    input  wire ssrc_pkg::ssrc_byte_type TX_DATA_IN,
    input  wire logic            TX_VALID_IN,
    output logic                 TX_READY_OUT,
    output logic                 SEND_STROBE_OUT,
    output logic [7:0]           SEND_DATA_OUT,
    input  wire logic            ACK_PIN_IN,
    input  wire logic            REQ_PIN_IN,
    input  wire ssrc_pkg::ssrc_byte_type RX_DATA_PIN_IN,
    output logic [7:0]           RX_DATA_OUT,
    output logic                 RX_VALID_OUT,
    output logic                 ROLE_TARGET_OUT,
    output logic                 QUAD_ENABLE_OUT,
    output logic                 ACTIVE_NEG_OUT
);
    import ssrc_pkg::*;

    // software registers
    ssrc_byte_type divctl_ff;     // divider control
    ssrc_byte_type extra_ff;      // extra setup and hold, DT mode
    ssrc_byte_type xferofs_ff;    // offset limit and role
    ssrc_byte_type quadtst_ff;    // quadrupler enable
    ssrc_byte_type test3_ff;      // active negation enable
    ssrc_byte_type rdata_ff;      // read answer
    // derived timing
    logic [7:0]    rx_period_ff;  // receive period, half input clocks
    logic [7:0]    tx_period_ff;  // send period, half input clocks
    logic [7:0]    send_period;
    logic [7:0]    rx_period;
    logic [7:0]    step;          // half input clocks per core cycle
    // send engine
    ssrc_send_state_type state_ff;
    logic [7:0]    count_ff;      // remaining half input clocks of this period
    logic [7:0]    half_ff;       // strobe release point for ST
    logic          strobe_ff;
    ssrc_byte_type sdata_ff;
    logic [6:0]    pending_ff;    // strobes not yet acknowledged
    logic          credit_ok;
    logic          issue;
    logic          dt_mode;
    // pin synchronisers
    logic          ack_meta_ff, ack_sync_ff, ack_prev_ff;
    logic          req_meta_ff, req_sync_ff, req_prev_ff;
    ssrc_byte_type rxd_meta_ff, rxd_sync_ff;
    logic          ack_evt;
    logic          rx_edge;
    ssrc_byte_type rx_data_ff;
    logic          rx_valid_ff;

    ssrc_buf_if txq ();

    // divisor in half input clocks, shared by send and receive timing
    function automatic logic [7:0] divisor_half(input logic [2:0] scf);
        logic [7:0] d;
        d = 8'h06;
        case (scf)
            3'h0:    d = 8'h06;
            3'h1:    d = 8'h02;
            3'h2:    d = 8'h03;
            3'h3:    d = 8'h04;
            3'h4:    d = 8'h06;
            3'h5:    d = 8'h08;
            3'h6:    d = 8'h0C;
            default: d = 8'h10;
        endcase
        return d;
    endfunction : divisor_half

    // send period in half input clocks
    function automatic logic [7:0] send_half(input logic [2:0] scf, input ssrc_byte_type x, input logic dt);
        logic [7:0] d;
        logic [7:0] sum;
        d   = divisor_half(scf);
        sum = 8'h00;
        if (dt) begin
            // all four extra clocks count, each worth half the divisor, a quarter of the DT base period
            sum = {7'h00, x[`SSRC_XH_DT_BIT]} + {7'h00, x[`SSRC_XH_ST_BIT]}
                + {7'h00, x[`SSRC_XS_DT_BIT]} + {7'h00, x[`SSRC_XS_ST_BIT]};
            return (d * (8'h04 + sum)) >> 1;
        end else begin
            // DT-edge bits are ignored for ST sends
            sum = {7'h00, x[`SSRC_XH_ST_BIT]} + {7'h00, x[`SSRC_XS_ST_BIT]};
            return d * (8'h04 + sum);
        end
    endfunction : send_half

    // receive period uses only the divisor and the mode
    function automatic logic [7:0] recv_half(input logic [2:0] scf, input logic dt);
        logic [7:0] d;
        d = divisor_half(scf);
        return dt ? (d << 1) : (d << 2);
    endfunction : recv_half

    assign dt_mode     = extra_ff[`SSRC_DT_MODE_BIT];
    assign send_period = send_half(divctl_ff[`SSRC_SCF_MSB:`SSRC_SCF_LSB], extra_ff, dt_mode);
    assign rx_period   = recv_half(divctl_ff[`SSRC_SCF_MSB:`SSRC_SCF_LSB], dt_mode);
    // quadrupler gives four input clocks per core cycle; faster rates saturate at one strobe a cycle
    assign step = quadtst_ff[`SSRC_QUAD_EN_BIT] ? `SSRC_HALF_STEP_QUAD : `SSRC_HALF_STEP_BASE;

    // register writes, accepted at any time so the engine may retune between moves
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            divctl_ff  <= `SSRC_RST_REG;
            extra_ff   <= `SSRC_RST_REG;
            xferofs_ff <= `SSRC_RST_REG;
            quadtst_ff <= `SSRC_RST_REG;
            test3_ff   <= `SSRC_RST_REG;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `SSRC_OFS_DIVCTL) begin
                divctl_ff <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SSRC_OFS_EXTRA) begin
                extra_ff <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SSRC_OFS_XFEROFS) begin
                xferofs_ff <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SSRC_OFS_QUADTST) begin
                quadtst_ff <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `SSRC_OFS_TEST3) begin
                test3_ff <= REG_WDATA_IN;
            end
        end
    end

    // read answer stands one cycle, zero otherwise and for unmapped offsets
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rdata_ff <= 8'h00;
        end else if (!REG_RD_IN) begin
            rdata_ff <= 8'h00;
        end else if (REG_ADDR_IN == `SSRC_OFS_DIVCTL) begin
            rdata_ff <= divctl_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_EXTRA) begin
            rdata_ff <= extra_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_XFEROFS) begin
            rdata_ff <= xferofs_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_QUADTST) begin
            rdata_ff <= quadtst_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_TEST3) begin
            rdata_ff <= test3_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_STATUS) begin
            // fastest mode is only legal once active negation is on
            rdata_ff <= {2'h0, !credit_ok, txq.drain_valid, state_ff == SND_HOLD,
                         quadtst_ff[`SSRC_QUAD_EN_BIT] && test3_ff[`SSRC_ACTNEG_BIT] && dt_mode,
                         dt_mode, quadtst_ff[`SSRC_QUAD_EN_BIT]};
        end else if (REG_ADDR_IN == `SSRC_OFS_RXPER) begin
            rdata_ff <= rx_period_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_TXPER) begin
            rdata_ff <= tx_period_ff;
        end else if (REG_ADDR_IN == `SSRC_OFS_PENDING) begin
            rdata_ff <= {1'b0, pending_ff};
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // registered copies of the derived periods for software to check
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rx_period_ff <= 8'h00;
            tx_period_ff <= 8'h00;
        end else begin
            rx_period_ff <= rx_period;
            tx_period_ff <= send_period;
        end
    end

    // two-flop synchronisers on every far-party pin
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ack_meta_ff <= 1'b0;
            ack_sync_ff <= 1'b0;
            ack_prev_ff <= 1'b0;
            req_meta_ff <= 1'b0;
            req_sync_ff <= 1'b0;
            req_prev_ff <= 1'b0;
            rxd_meta_ff <= 8'h00;
            rxd_sync_ff <= 8'h00;
        end else begin
            ack_meta_ff <= ACK_PIN_IN;
            ack_sync_ff <= ack_meta_ff;
            ack_prev_ff <= ack_sync_ff;
            req_meta_ff <= REQ_PIN_IN;
            req_sync_ff <= req_meta_ff;
            req_prev_ff <= req_sync_ff;
            rxd_meta_ff <= RX_DATA_PIN_IN;
            rxd_sync_ff <= rxd_meta_ff;
        end
    end

    // DT counts both edges of a strobe, ST only the asserting edge
    assign ack_evt = (dt_mode ? (ack_sync_ff ^ ack_prev_ff) : (ack_sync_ff && !ack_prev_ff))
                     && (pending_ff != 7'h00);
    assign rx_edge = dt_mode ? (req_sync_ff ^ req_prev_ff) : (req_sync_ff && !req_prev_ff);

    // receive path never waits on the send timing
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rx_valid_ff <= 1'b0;
            rx_data_ff  <= 8'h00;
        end else begin
            rx_valid_ff <= rx_edge;
            if (rx_edge) begin
                rx_data_ff <= rxd_sync_ff;
            end
        end
    end

    ssrc_skid_buffer u_txq (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .bus    (txq)
    );
    assign txq.fill_valid = TX_VALID_IN;
    assign txq.fill_data  = TX_DATA_IN;

    // offset credit; a zero offset blocks synchronous sending entirely
    assign credit_ok = ({1'b0, pending_ff} < {2'h0, xferofs_ff[`SSRC_OFS_MSB:0]});
    // a new strobe may start in the last cycle of the previous period
    assign txq.drain_ready = credit_ok && ((state_ff == SND_IDLE) || (count_ff <= step));
    assign issue = txq.drain_ready && txq.drain_valid;

    // send timing engine, same for initiator and target roles
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_ff  <= SND_IDLE;
            count_ff  <= 8'h00;
            half_ff   <= 8'h00;
            strobe_ff <= 1'b0;
            sdata_ff  <= 8'h00;
        end else begin
            case (state_ff)
                SND_IDLE: begin
                    if (issue) begin
                        state_ff  <= SND_HOLD;
                        count_ff  <= send_period;
                        half_ff   <= send_period >> 1;
                        strobe_ff <= dt_mode ? !strobe_ff : 1'b1;
                        sdata_ff  <= txq.drain_data;
                    end else if (!dt_mode) begin
                        strobe_ff <= 1'b0;
                    end
                end
                SND_HOLD: begin
                    if (issue) begin
                        count_ff  <= send_period;
                        half_ff   <= send_period >> 1;
                        strobe_ff <= dt_mode ? !strobe_ff : 1'b1;
                        sdata_ff  <= txq.drain_data;
                    end else if (count_ff <= step) begin
                        // period over and nothing to send
                        state_ff <= SND_IDLE;
                        count_ff <= 8'h00;
                        if (!dt_mode) begin
                            strobe_ff <= 1'b0;
                        end
                    end else begin
                        count_ff <= count_ff - step;
                        // ST strobe is released halfway through its period
                        if (!dt_mode && ((count_ff - step) <= half_ff)) begin
                            strobe_ff <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_ff <= SND_IDLE;
                end
            endcase
        end
    end

    // unacknowledged transfer count; issue and acknowledge in one cycle cancel
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pending_ff <= 7'h00;
        end else if (issue && !ack_evt) begin
            pending_ff <= pending_ff + 7'h01;
        end else if (ack_evt && !issue) begin
            pending_ff <= pending_ff - 7'h01;
        end
    end

    assign REG_RDATA_OUT   = rdata_ff;
    assign TX_READY_OUT    = txq.fill_ready;
    assign SEND_STROBE_OUT = strobe_ff;
    assign SEND_DATA_OUT   = sdata_ff;
    assign RX_DATA_OUT     = rx_data_ff;
    assign RX_VALID_OUT    = rx_valid_ff;
    assign ROLE_TARGET_OUT = xferofs_ff[`SSRC_ROLE_BIT];
    assign QUAD_ENABLE_OUT = quadtst_ff[`SSRC_QUAD_EN_BIT];
    assign ACTIVE_NEG_OUT  = test3_ff[`SSRC_ACTNEG_BIT];

    AST_DIV_WRITE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (REG_WR_IN && REG_ADDR_IN == `SSRC_OFS_DIVCTL && !dt_mode && REG_WDATA_IN[6:4] == 3'h7)
        |=> ##1 (rx_period_ff == 8'h40))
        else $error("divide by eight not reflected in receive period");
    AST_DECODE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!dt_mode && divctl_ff[6:4] == 3'h2) |-> (rx_period == 8'h0C))
        else $error("divide by one and a half decoded wrong");
    AST_RX_INDEP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (REG_WR_IN && REG_ADDR_IN == `SSRC_OFS_EXTRA && REG_WDATA_IN[7] == dt_mode)
        |=> ##1 $stable(rx_period_ff))
        else $error("extra clocks changed the receive period");
    AST_RX_RATE_DT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (dt_mode && divctl_ff[6:4] == 3'h1) |-> (rx_period == 8'h04))
        else $error("DT receive period not twice the divisor");
    AST_DT_PERIOD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (dt_mode && divctl_ff[6:4] == 3'h1 && extra_ff[3:0] == 4'hF) |-> (send_period == 8'h08))
        else $error("DT send period with all extra clocks wrong");
    AST_ST_IGNORES_DT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!dt_mode && divctl_ff[6:4] == 3'h3 && extra_ff[2] && !extra_ff[0]) |-> (send_period == 8'h14))
        else $error("ST send period affected by DT-edge bits or hold lost");
    AST_CREDIT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        ({1'b0, pending_ff} >= {2'h0, xferofs_ff[5:0]}) |-> !issue)
        else $error("strobe issued at the offset limit");
    AST_PENDING_UP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (issue && !ack_evt) |=> (pending_ff == $past(pending_ff) + 7'h01) && (state_ff == SND_HOLD))
        else $error("outstanding count did not follow a strobe");
    AST_QUAD_RESET: assert property (@(posedge CLK_IN)
        $past(RST_IN) && !RST_IN |-> !QUAD_ENABLE_OUT && (step == `SSRC_HALF_STEP_BASE))
        else $error("quadrupler active after reset");
    AST_RX_ACCEPT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        rx_edge |=> RX_VALID_OUT && (RX_DATA_OUT == $past(rxd_sync_ff)))
        else $error("receive strobe dropped");
    AST_READBACK: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (REG_RD_IN && REG_ADDR_IN == `SSRC_OFS_XFEROFS) |=> (REG_RDATA_OUT == $past(xferofs_ff)))
        else $error("offset register read back wrong");
    AST_SPACING: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (issue && !dt_mode && send_period == 8'h10 && !quadtst_ff[3]) |=> !issue [*7])
        else $error("ST strobes closer than the send period");

    COV_DT_SEND: cover property (@(posedge CLK_IN) disable iff (RST_IN) issue && dt_mode);
    COV_LIMIT:   cover property (@(posedge CLK_IN) disable iff (RST_IN) !credit_ok && txq.drain_valid);
    COV_RX_BUSY: cover property (@(posedge CLK_IN) disable iff (RST_IN) rx_edge && state_ff == SND_HOLD);
    COV_QUAD:    cover property (@(posedge CLK_IN) disable iff (RST_IN) issue && QUAD_ENABLE_OUT);
endmodule : ssrc_rate_clocking
`default_nettype wire

// *** rtl/ssrc_skid_buffer.sv ***
// two-entry buffer holding send bytes until the rate engine takes them
// assumes synchronous active-high reset on the shared clock
`timescale 1ns/1ps
`default_nettype none
module ssrc_skid_buffer (
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    ssrc_buf_if.store   bus
);
    import ssrc_pkg::*;
    ssrc_byte_type mem_ff [2];   // storage entries
    logic          wr_ptr_ff;    // next entry to fill
    logic          rd_ptr_ff;    // next entry to drain
    logic [1:0]    count_ff;     // entries in use
    logic          ready_ff;     // registered room flag
    logic          push;
    logic          pop;
    logic [1:0]    nxt_count;

    assign push = bus.fill_valid && ready_ff;
    assign pop  = bus.drain_ready && (count_ff != 2'h0);
    assign nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    assign bus.fill_ready  = ready_ff;
    assign bus.drain_valid = (count_ff != 2'h0);
    assign bus.drain_data  = mem_ff[rd_ptr_ff];

    // occupancy and ready; ready is registered so the top drives it from a flop
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_ff  <= 2'h0;
            ready_ff  <= 1'b0;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
        end else begin
            count_ff  <= nxt_count;
            ready_ff  <= (nxt_count != 2'h2);
            wr_ptr_ff <= wr_ptr_ff ^ push;
            rd_ptr_ff <= rd_ptr_ff ^ pop;
        end
    end

    // data entries need no reset, valid is tracked by count
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= bus.fill_data;
        end
    end

    AST_BUF_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (rst_in) count_ff != 2'h3)
        else $error("buffer occupancy beyond two");
endmodule : ssrc_skid_buffer
`default_nettype wire

// *** verification/ssrc_far_party.sv ***
// far party model: acknowledges each send strobe, may stall
// assumes the core clock; the device syncs the ack pin
`timescale 1ns/1ps
`default_nettype none
module ssrc_far_party (
    input  wire logic clk_in,
    input  wire logic dt_in,
    input  wire logic stall_in,
    input  wire logic strobe_in,
    output logic      ack_out = 1'b0
);
    logic last_ff = 1'b0; // strobe level last cycle
    int   owed    = 0;    // strobes not yet acked
    int   gap     = 0;    // cycles since last ack edge
    // ack edges three cycles apart so the synchroniser never merges two
    always @(posedge clk_in) begin
        last_ff <= strobe_in;
        if (dt_in ? strobe_in != last_ff : strobe_in && !last_ff) begin
            owed = owed + 1;
        end
        gap = gap + 1;
        if (gap > 2 && !dt_in && ack_out) begin // st: end of pulse
            ack_out <= 1'b0;
            gap = 0;
        end else if (gap > 2 && owed > 0 && !stall_in) begin // st rise or dt edge
            ack_out <= !ack_out;
            owed = owed - 1;
            gap = 0;
        end
    end
endmodule : ssrc_far_party
`default_nettype wire

// *** verification/tb_top.sv ***
// bench: registers, periods, offset credit, receive path
// assumes the far party model; 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ssrc_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, txv = 0, req = 0, dt = 0, stall = 1, lst = 0;
    logic txr, stb, ack, rxv, role, quad, an;
    ssrc_addr_type addr = 4'h0;
    ssrc_byte_type wd = 8'h00, txd = 8'h00, rxp = 8'h00, got;
    logic [7:0] rdat, sdat, rxd;
    ssrc_byte_type sent[$], seen[$], rxe[$], rxq[$]; // pushed, strobed, driven, received
    int fails = 0, n_tests = 0, cyc = 0, gap = 0, g1 = 0;
    int dtab[8] = '{6, 2, 3, 4, 6, 8, 12, 16}; // divisor in half clocks
    ssrc_rate_clocking i_ssrc_rate_clocking (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .TX_DATA_IN(txd), .TX_VALID_IN(txv),
        .TX_READY_OUT(txr), .SEND_STROBE_OUT(stb), .SEND_DATA_OUT(sdat), .ACK_PIN_IN(ack), .REQ_PIN_IN(req),
        .RX_DATA_PIN_IN(rxp), .RX_DATA_OUT(rxd), .RX_VALID_OUT(rxv), .ROLE_TARGET_OUT(role),
        .QUAD_ENABLE_OUT(quad), .ACTIVE_NEG_OUT(an));
    ssrc_far_party i_ssrc_far_party (.clk_in(clk), .dt_in(dt), .stall_in(stall), .strobe_in(stb), .ack_out(ack));
    always #12.5 clk = ~clk;
    // watchdog; collect strobed and received bytes
    always @(posedge clk) begin
        cyc = cyc + 1;
        gap = gap + 1;
        lst <= stb;
        if (rxv === 1'b1) rxq.push_back(rxd);
        if (dt ? stb != lst : stb && !lst) begin
            if (seen.size() == 1) g1 = gap;
            seen.push_back(sdat);
            gap = 0;
        end
        if (cyc > 6000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic cmp(string w, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : cmp
    task automatic wreg(ssrc_addr_type a, ssrc_byte_type d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rchk(ssrc_addr_type a, ssrc_byte_type m, ssrc_byte_type e, string w);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(w, e & m, rdat & m);
    endtask : rchk
    // called just after an edge; valid stays up between back-to-back pushes, caller drops it
    task automatic push(ssrc_byte_type d);
        txd <= d;
        txv <= 1'b1;
        sent.push_back(d);
        do @(posedge clk); while (txr !== 1'b1);
    endtask : push
    // receive strobes while sending: data held over the edge, then inverted
    task automatic recv(int n);
        ssrc_byte_type d;
        repeat (n) begin
            d = 8'($urandom);
            rxe.push_back(d);
            @(posedge clk);
            rxp <= d;
            repeat (2) @(posedge clk);
            req <= dt ? ~req : 1'b1;
            repeat (4) @(posedge clk);
            rxp <= ~d;
            req <= dt & req;
        end
    endtask : recv
    task automatic send_run(ssrc_byte_type ofs, logic [7:0] eg);
        sent.delete();
        seen.delete();
        rxe.delete();
        rxq.delete();
        stall <= 1'b1;
        wreg(4'h2, ofs);
        fork
            begin
                repeat (6) push(8'($urandom));
                txv <= 1'b0;
            end
            recv(4);
            begin
                repeat (70) @(posedge clk);
                cmp("held strobes", ofs & 8'h3F, 8'(seen.size()));
                cmp("ready when full", 8'h00, 8'(txr));
                stall <= 1'b0;
            end
        join
        repeat (200) @(posedge clk);
        cmp("role", 8'(ofs[7]), 8'(role));
        cmp("strobe spacing", eg, 8'(g1));
        cmp("bytes sent", 8'd6, 8'(seen.size()));
        foreach (sent[i]) cmp("send data", sent[i], seen[i]);
        foreach (rxe[i]) cmp("received", rxe[i], rxq[i]);
        rchk(4'h8, 8'hFF, 8'h00, "pending after acks");
        $display("send run with offset %h done", ofs);
    endtask : send_run
    function automatic ssrc_byte_type sp(int s, ssrc_byte_type x);
        if (x[7]) return 8'(dtab[s] * (4 + x[0] + x[1] + x[2] + x[3]) / 2);
        return 8'(dtab[s] * (4 + x[0] + x[2]));
    endfunction : sp
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        void'($urandom(38));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            // zero offset stalls credit; divisor select 000 is divide by three, ST
            rchk(4'(a), 8'hFF, (a == 5) ? 8'h20 : ((a == 6 || a == 7) ? 8'h18 : 8'h00), "reset value");
        end
        cmp("quad at reset", 8'h00, 8'(quad));
        $display("reset values done");
        for (int s = 0; s < 8; s++) begin
            got = 8'($urandom) & 8'h8F;
            if (s == 2) got[3:2] = got[1:0];
            // fixed corners: all DT extras at divide by one, ST with DT bits at divide by two
            if (s == 2 || s == 6) got[7] = 1'b0;
            if (s == 1) got = 8'h8F;
            if (s == 3) got = 8'h0E;
            wreg(4'h0, 8'(s << 4));
            wreg(4'h1, got);
            rchk(4'h0, 8'h70, 8'(s << 4), "divisor select");
            rchk(4'h7, 8'hFF, sp(s, got), "send period");
            rchk(4'h6, 8'hFF, 8'(dtab[s] * (got[7] ? 2 : 4)), "receive period");
        end
        $display("period table done");
        wreg(4'h1, 8'h00);
        wreg(4'h0, 8'h30);
        send_run(8'h02, 8'd8);
        send_run(8'h83, 8'd8);
        dt <= 1'b1;
        wreg(4'h3, 8'h08);
        wreg(4'h4, 8'h80);
        wreg(4'h0, 8'h18);
        wreg(4'h2, 8'h3E);
        wreg(4'h1, 8'h80);
        wreg(4'h7, 8'hFF);
        rchk(4'h2, 8'hBF, 8'h3E, "offset");
        rchk(4'h7, 8'hFF, 8'h04, "fastest send period");
        rchk(4'h6, 8'hFF, 8'h04, "fastest receive period");
        rchk(4'h5, 8'h07, 8'h07, "status mode bits");
        cmp("quad and negation", 8'h03, 8'({quad, an}));
        send_run(8'h02, 8'd1);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
